// >>> common/aap_pkg.sv
/*
 * Types of the angle post-processing pipeline: the front-end state
 * enumeration and the single packed state record of the pipeline.
 * Assumes the register header is compiled alongside.
 */
`default_nettype none
package aap_pkg;

    // Raw angle computation sequencer.
    typedef enum logic [0:0] {
        AAP_IDLE = 1'b0,
        AAP_RUN = 1'b1
    } aap_cordic_e;

    // All state of the pipeline.
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] iir_shift;
        logic [15:0] temp_coeff;
        logic [15:0] temp_ref;
        logic [15:0] pre_gain_zero;
        logic [15:0] low_bound;
        logic [15:0] high_bound;
        logic [15:0] stroke_scale;
        logic [15:0] pre_corr_zero;
        logic [15:0] final_zero_shift;
        logic [15:0] upper_limit;
        logic [15:0] lower_limit;
        logic [15:0][15:0] coeffs;
        logic over_bound_flag;
        logic under_bound_flag;
        logic [11:0] angle_out;
        logic angle_valid;
        logic [15:0] rdata;
        logic [3:0] dec_cnt;
        logic signed [19:0] acc_x;
        logic signed [19:0] acc_y;
        logic signed [19:0] dc_x;
        logic signed [19:0] dc_y;
        aap_cordic_e cst;
        logic [3:0] iter;
        logic signed [21:0] cx;
        logic signed [21:0] cy;
        logic [15:0] cz;
        logic [15:0] raw;
        logic raw_ok;
        logic [8:0] tick_cnt;
        logic [6:0] avg_cnt;
        logic [15:0] avg_first;
        logic signed [23:0] avg_sum;
        logic [15:0] iir_y;
        logic iir_init;
        logic chop;
    } aap_state_s;

endpackage : aap_pkg
`default_nettype wire

// >>> common/aap_regs.svh
/*
 * Register offsets, control bit positions, reset values and timing
 * figures of the angle post-processing pipeline.
 * Assumes a 5-bit word address on the plain register port.
 */
`ifndef AAP_REGS_SVH
`define AAP_REGS_SVH

// Register offsets.
`define AAP_CTRL        5'h00
`define AAP_IIR_SHIFT   5'h01
`define AAP_TEMP_COEFF  5'h02
`define AAP_TEMP_REF    5'h03
`define AAP_PRE_GAIN_Z  5'h04
`define AAP_LOW_BOUND   5'h05
`define AAP_HIGH_BOUND  5'h06
`define AAP_STROKE_SC   5'h07
`define AAP_PRE_CORR_Z  5'h08
`define AAP_FINAL_Z     5'h09
`define AAP_UPPER_LIM   5'h0a
`define AAP_LOWER_LIM   5'h0b
`define AAP_FAULT_WORD  5'h0c
`define AAP_ANGLE_OUT   5'h0d
`define AAP_RAW_ANGLE   5'h0e
`define AAP_COEFF_BASE  5'h10

// Control word bit positions.
`define AAP_RATE_LSB    0
`define AAP_IIR_ON      3
`define AAP_DIR         4
`define AAP_SHORT       5
`define AAP_HARM_ON     6
`define AAP_SEG_ON      7
`define AAP_POLARITY    8
`define AAP_DIE_ADJ     9
`define AAP_INVERT      10

// Fault word bit positions.
`define AAP_UNDER_BIT   0
`define AAP_OVER_BIT    1

// Reset values.
`define AAP_CTRL_RST    16'h0000
`define AAP_SCALE_RST   16'h0100
`define AAP_UPPER_RST   16'hffff
`define AAP_SHIFT_RST   16'h0002

// Timing: refresh base period and clock period, in ns.
`define AAP_T_BASE_NS   32000
`define AAP_T_CLK_NS    100

// Fixed-point positions.
`define AAP_SCALE_FRAC  8
`define AAP_TEMP_FRAC   12
`define AAP_ROUND_HALF  16'h0008
`define AAP_HALF_TURN   12'h800
`define AAP_DC_SHIFT    4
`define AAP_CORDIC_LAST 4'hd

`endif

// >>> dv/aap_conv_model.sv
/*
 * Converter model: quadrature samples of a target angle.
 * Assumes clk is the pipeline clock and target is set by the bench.
 */
`timescale 1ns/1ns
`default_nettype none
module aap_conv_model (
    // Clock, reset and target.
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] target,
    // Converter samples.
    output logic conv_valid,
    output logic signed [15:0] conv_x,
    output logic signed [15:0] conv_y
);
    logic [1:0] div;
    logic [1:0] nsamp;
    real ph;

    // One sample every fourth cycle; between samples the data flips.
    // Every other pair is turned half a turn: a chopped carrier.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div <= 2'h0;
            nsamp <= 2'h0;
            conv_valid <= 1'b0;
            conv_x <= 16'sh0;
            conv_y <= 16'sh0;
        end else begin
            div <= div + 2'h1;
            conv_valid <= (div == 2'h3);
            ph = 6.283185307 * (target + {nsamp[1], 15'h0}) / 65536.0;
            if (div == 2'h3) begin
                nsamp <= nsamp + 2'h1;
                conv_x <= 16'(int'(12000.0 * $cos(ph)));
                conv_y <= 16'(int'(12000.0 * $sin(ph)));
            end else begin
                conv_x <= ~conv_x;
                conv_y <= ~conv_y;
            end
        end
    end
endmodule : aap_conv_model
`default_nettype wire

// >>> dv/aap_pipeline_props.sv
/*
 * Port checker of the angle pipeline, bound into each instance.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ns
`default_nettype none
`include "aap_regs.svh"
module aap_pipeline_props #(
    parameter int DECIM = 2
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Inputs of the pipeline.
    input wire logic conv_valid,
    input wire logic signed [15:0] conv_x,
    input wire logic signed [15:0] conv_y,
    input wire logic signed [15:0] temp_in,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    // Outputs of the pipeline.
    input wire logic [15:0] reg_rdata,
    input wire logic [11:0] angle_out,
    input wire logic angle_valid,
    input wire logic over_bound_flag,
    input wire logic under_bound_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    logic [15:0] gap;
    logic seen;

    // Cycles since the last refresh; saturates at 16'hffff, above the 40960-cycle gap of rate 7.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gap <= 16'h0000;
            seen <= 1'b0;
        end else if (angle_valid) begin
            gap <= 16'h0000;
            seen <= 1'b1;
        end else if (gap != 16'hffff) begin
            gap <= gap + 16'h0001;
        end
    end

    rdata_idle_a:
        assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
        else $error("read data not idle");
    valid_pulse_a:
        assert property (angle_valid |=> !angle_valid)
        else $error("refresh strobe too long");
    angle_hold_a:
        assert property (!angle_valid |-> $stable(angle_out))
        else $error("angle changed without refresh");
    refresh_gap_a:
        assert property (angle_valid && seen |-> gap >= 16'd319)
        else $error("refresh came too soon");
    angle_read_a:
        assert property ($past(reg_read) && $past(reg_addr) ==
            `AAP_ANGLE_OUT |-> reg_rdata == {4'h0, $past(angle_out)})
        else $error("angle readback wrong");
    fault_read_a:
        assert property ($past(reg_read) && $past(reg_addr) ==
            `AAP_FAULT_WORD |-> reg_rdata == {14'h0,
            $past(over_bound_flag), $past(under_bound_flag)})
        else $error("fault readback wrong");
    over_clear_a:
        assert property ($fell(over_bound_flag) |-> $past(reg_write)
            && $past(reg_addr) == `AAP_FAULT_WORD && $past(reg_wdata[1]))
        else $error("over flag fell by itself");
    under_clear_a:
        assert property ($fell(under_bound_flag) |-> $past(reg_write)
            && $past(reg_addr) == `AAP_FAULT_WORD && $past(reg_wdata[0]))
        else $error("under flag fell by itself");

    valid_seen_c: cover property (angle_valid);
    both_seen_c: cover property (over_bound_flag && under_bound_flag);
    clear_seen_c: cover property ($fell(over_bound_flag));
endmodule : aap_pipeline_props

bind aap_pipeline aap_pipeline_props #(.DECIM(DECIM)) u_aap_pipeline_props (
    .clk(clk), .resetn(resetn), .conv_valid(conv_valid),
    .conv_x(conv_x), .conv_y(conv_y), .temp_in(temp_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .angle_out(angle_out),
    .angle_valid(angle_valid), .over_bound_flag(over_bound_flag),
    .under_bound_flag(under_bound_flag)
);
`default_nettype wire

// >>> dv/tb_top.sv
/*
 * Bench of the angle pipeline: register tasks and settings with codes.
 * Assumes the converter model and the checker compile first.
 */
`timescale 1ns/1ns
`default_nettype none
`include "aap_regs.svh"
module tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic signed [15:0] temp_in = 16'sh0;
    logic [15:0] target = 16'h2000;
    logic conv_valid;
    logic signed [15:0] conv_x;
    logic signed [15:0] conv_y;
    logic [15:0] reg_rdata;
    logic [11:0] angle_out;
    logic angle_valid;
    logic over_bound_flag;
    logic under_bound_flag;
    logic [15:0] rv;
    int n_mismatch = 0;
    int checks = 0;
    int gap;

    // Free-running 10 MHz clock.
    initial begin
        forever #50 clk = ~clk;
    end

    aap_conv_model u_aap_conv_model (.clk(clk), .resetn(resetn),
        .target(target), .conv_valid(conv_valid), .conv_x(conv_x),
        .conv_y(conv_y));
    aap_pipeline #(.DECIM(2)) u_aap_pipeline (.clk(clk), .resetn(resetn),
        .conv_valid(conv_valid), .conv_x(conv_x), .conv_y(conv_y),
        .temp_in(temp_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .angle_out(angle_out), .angle_valid(angle_valid),
        .over_bound_flag(over_bound_flag),
        .under_bound_flag(under_bound_flag));

    task automatic report_and_stop;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd

    task automatic cmp(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : cmp

    // Codes match within two steps, since the vector angle is quantised.
    task automatic near(input string n, input logic [11:0] e,
                        input logic [11:0] g);
        logic [11:0] d;
        d = g - e;
        checks++;
        if ($isunknown(g) || (d > 12'h002 && d < 12'hffe)) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : near

    // Waits for a refresh strobe under a bound, counting the cycles.
    task automatic wait_v;
        gap = 0;
        do begin
            @(posedge clk);
            #1 gap++;
        end while (angle_valid !== 1'b1 && gap < 6000);
        if (gap >= 6000) begin
            n_mismatch++;
            $display("MISMATCH angle_valid expected 1 seen 0");
        end
    endtask : wait_v

    task automatic chk(input logic [15:0] c, input logic [11:0] e);
        wr(`AAP_CTRL, c);
        repeat (3) wait_v;
        near("angle_out", e, angle_out);
    endtask : chk

    // Main sequence: reset values, timing, then each stage in turn.
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd(`AAP_CTRL);
        cmp("ctrl", 16'h0000, rv);
        rd(`AAP_IIR_SHIFT);
        cmp("iir_shift", 16'h0002, rv);
        rd(`AAP_STROKE_SC);
        cmp("stroke_scale", 16'h0100, rv);
        rd(`AAP_UPPER_LIM);
        cmp("upper_limit", 16'hffff, rv);
        rd(5'h0f);
        cmp("unmapped", 16'h0000, rv);
        wr(`AAP_ANGLE_OUT, 16'h0abc);
        rd(`AAP_ANGLE_OUT);
        cmp("angle_ro", 16'h0000, rv);
        chk(16'h0000, 12'h200);
        rd(`AAP_RAW_ANGLE);
        near("raw", 12'h200, rv[15:4]);
        cmp("fault", 16'h0, {14'h0, over_bound_flag, under_bound_flag});
        repeat (2) wait_v;
        cmp("gap0", 16'd320, 16'(gap));
        chk(16'h0003, 12'h200);
        wait_v;
        cmp("gap3", 16'd2560, 16'(gap));
        chk(16'h0000, 12'h200);
        wr(`AAP_PRE_GAIN_Z, 16'h3000);
        chk(16'h0000, 12'hf00);
        wr(`AAP_PRE_GAIN_Z, 16'h0000);
        wr(`AAP_PRE_CORR_Z, 16'h0800);
        wr(`AAP_FINAL_Z, 16'h0800);
        chk(16'h0000, 12'h100);
        wr(`AAP_FINAL_Z, 16'h0000);
        wr(`AAP_PRE_CORR_Z, 16'h0000);
        chk(16'h0100, 12'he00);
        chk(16'h0010, 12'he00);
        chk(16'h0110, 12'h200);
        chk(16'h0200, 12'ha00);
        chk(16'h0008, 12'h200);
        wr(`AAP_COEFF_BASE + 5'h02, 16'h0100);
        chk(16'h0040, 12'h1f8);
        chk(16'h0080, 12'h1f0);
        wr(`AAP_TEMP_COEFF, 16'h1000);
        temp_in <= 16'sh0100;
        chk(16'h0000, 12'h210);
        wr(`AAP_TEMP_COEFF, 16'h0000);
        wr(`AAP_LOW_BOUND, 16'h1000);
        wr(`AAP_HIGH_BOUND, 16'h1800);
        chk(16'h0020, 12'h200);
        cmp("fault", 16'h2, {14'h0, over_bound_flag, under_bound_flag});
        target <= 16'h0800;
        chk(16'h0020, 12'h080);
        cmp("fault", 16'h3, {14'h0, over_bound_flag, under_bound_flag});
        rd(`AAP_FAULT_WORD);
        cmp("fault_rd", 16'h3, rv);
        wr(`AAP_LOW_BOUND, 16'h0000);
        wr(`AAP_HIGH_BOUND, 16'hf000);
        wr(`AAP_FAULT_WORD, 16'h0003);
        chk(16'h0020, 12'h080);
        cmp("fault", 16'h0, {14'h0, over_bound_flag, under_bound_flag});
        wr(`AAP_STROKE_SC, 16'h0200);
        chk(16'h0020, 12'h100);
        wr(`AAP_UPPER_LIM, 16'h0c00);
        chk(16'h0020, 12'h0c0);
        wr(`AAP_UPPER_LIM, 16'hffff);
        wr(`AAP_LOWER_LIM, 16'h2000);
        chk(16'h0020, 12'h200);
        chk(16'h0420, 12'hfff);
        report_and_stop;
    end

    // Hang guard: the sequence needs roughly 30000 cycles.
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        report_and_stop;
    end
endmodule : tb_top
`default_nettype wire

// >>> hdl/aap_pipeline.sv
/*
 * Angle post-processing pipeline: front end, averaging, filtering,
 * compensation, offsets, bounds, gain, linearization, clamp,
 * rounding and die adjust, with a plain register port.
 * Assumes converter samples and temperature are synchronous to clk.
 */
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "aap_regs.svh"
module aap_pipeline #(
    parameter int DECIM = 2
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Converter samples and die temperature.
    input wire logic conv_valid,
    input wire logic signed [15:0] conv_x,
    input wire logic signed [15:0] conv_y,
    input wire logic signed [15:0] temp_in,
    // Register port.
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    // Processed angle.
    output logic [11:0] angle_out,
    output logic angle_valid,
    output logic over_bound_flag,
    output logic under_bound_flag
);
    localparam int TICK_CYC = `AAP_T_BASE_NS / `AAP_T_CLK_NS;
    localparam logic [8:0] TICK_LAST = 9'(TICK_CYC - 1);
    localparam logic [3:0] DEC_LAST = 4'(DECIM - 1);

    aap_pkg::aap_state_s s;
    aap_pkg::aap_state_s next_s;

    // Arc tangent of 2^-i in units of a 65536-step turn.
    function automatic logic [15:0] atan_step(input logic [3:0] i);
        case (i)
            4'h0: atan_step = 16'h2000;
            4'h1: atan_step = 16'h12e4;
            4'h2: atan_step = 16'h09fb;
            4'h3: atan_step = 16'h0511;
            4'h4: atan_step = 16'h028b;
            4'h5: atan_step = 16'h0146;
            4'h6: atan_step = 16'h00a3;
            4'h7: atan_step = 16'h0051;
            4'h8: atan_step = 16'h0029;
            4'h9: atan_step = 16'h0014;
            4'ha: atan_step = 16'h000a;
            4'hb: atan_step = 16'h0005;
            4'hc: atan_step = 16'h0003;
            default: atan_step = 16'h0001;
        endcase
    endfunction : atan_step

    // Triangle approximation of a sine over one turn, signed.
    function automatic logic signed [15:0] tri_wave(
        input logic [15:0] p);
        logic [15:0] q;
        q = p + 16'h4000;
        if (q[15]) begin
            tri_wave = 16'(16'h7fff - {q[14:0], 1'b0});
        end else begin
            tri_wave = 16'(16'h8000 + {q[14:0], 1'b0});
        end
    endfunction : tri_wave

    // Angle processing from the averaged value to the 12-bit output.
    function automatic logic [11:0] process_angle(
        input aap_pkg::aap_state_s r,
        input logic [15:0] avg,
        input logic signed [15:0] temp,
        output logic over_hit,
        output logic under_hit);
        logic [15:0] a;
        logic short;
        logic signed [31:0] tprod;
        logic [31:0] gprod;
        logic signed [31:0] hsum;
        logic [3:0] idx;
        logic signed [15:0] c0;
        logic signed [15:0] c1;
        logic signed [31:0] slope;
        logic signed [15:0] err;
        logic [16:0] rnd;
        logic [11:0] o;
        logic [12:0] isum;
        a = avg;
        short = r.ctrl[`AAP_SHORT];
        over_hit = 1'b0;
        under_hit = 1'b0;
        // Linear drift against the reference temperature.
        tprod = 32'(signed'(16'(temp - signed'(r.temp_ref))))
              * 32'(signed'(r.temp_coeff));
        a = a + 16'(tprod >>> `AAP_TEMP_FRAC);
        if (r.ctrl[`AAP_DIR]) begin
            a = 16'(-a);
        end
        a = a - r.pre_gain_zero;
        // Bounds are checked on the angle before gain.
        if (short) begin
            over_hit = a > r.high_bound;
            under_hit = a < r.low_bound;
            gprod = 32'(a) * 32'(r.stroke_scale);
            gprod = gprod >> `AAP_SCALE_FRAC;
            // Saturate rather than wrap a scaled stroke.
            a = (gprod[31:16] != 16'h0000) ? 16'hffff
                : gprod[15:0];
        end
        // First four harmonics, amplitudes in the first four entries.
        hsum = 32'sh0;
        if (r.ctrl[`AAP_HARM_ON]) begin
            for (int h = 1; h <= 4; h++) begin
                hsum = hsum + 32'(signed'(r.coeffs[h - 1]))
                     * 32'(tri_wave(16'(a * 16'(h))));
            end
        end
        a = a - 16'(hsum >>> 15);
        a = a - r.pre_corr_zero;
        // Sixteen segments, error interpolated within each.
        idx = a[15:12];
        c0 = signed'(r.coeffs[idx]);
        c1 = signed'(r.coeffs[4'(idx + 4'h1)]);
        slope = 32'(signed'(17'(c1 - c0)))
              * 32'(signed'({1'b0, a[11:0]}));
        err = 16'(32'(c0) + (slope >>> 12));
        if (r.ctrl[`AAP_SEG_ON]) begin
            a = a - err;
        end
        a = a - r.final_zero_shift;
        if (r.ctrl[`AAP_POLARITY]) begin
            a = 16'(-a);
        end
        if (short) begin
            if (a > r.upper_limit) begin
                a = r.upper_limit;
            end else if (a < r.lower_limit) begin
                a = r.lower_limit;
            end
        end
        // Full turn rounds modulo; short stroke saturates at top.
        rnd = {1'b0, a} + {1'b0, `AAP_ROUND_HALF};
        if (rnd[16] && short) begin
            o = 12'hfff;
        end else begin
            o = rnd[15:4];
        end
        if (short && r.ctrl[`AAP_INVERT]) begin
            isum = {1'b0, r.upper_limit[15:4]}
                 + {1'b0, r.lower_limit[15:4]};
            o = 12'(isum - {1'b0, o});
        end
        if (r.ctrl[`AAP_DIE_ADJ]) begin
            o = o + `AAP_HALF_TURN;
        end
        process_angle = o;
    endfunction : process_angle

    // Next-state computation of the whole block.
    always_comb begin
        logic signed [19:0] hx;
        logic signed [19:0] hy;
        logic signed [21:0] sx;
        logic signed [21:0] sy;
        logic [15:0] delta;
        logic signed [23:0] sum;
        logic [15:0] avg;
        logic [15:0] iir_in;
        logic [15:0] diff;
        logic [2:0] rate;
        logic [6:0] avg_last;
        logic oh;
        logic uh;
        logic [11:0] res;
        hx = 20'sh0;
        hy = 20'sh0;
        sx = 22'sh0;
        sy = 22'sh0;
        delta = 16'h0;
        sum = 24'sh0;
        avg = 16'h0;
        iir_in = 16'h0;
        diff = 16'h0;
        oh = 1'b0;
        uh = 1'b0;
        res = 12'h0;
        rate = s.ctrl[`AAP_RATE_LSB +: 3];
        avg_last = 7'((8'h01 << rate) - 8'h01);
        next_s = s;
        next_s.angle_valid = 1'b0;
        // Decimation by summing samples is the low-pass half.
        if (conv_valid) begin
            if (s.dec_cnt == 4'h0) begin
                next_s.acc_x = 20'(conv_x);
                next_s.acc_y = 20'(conv_y);
            end else begin
                next_s.acc_x = s.acc_x + 20'(conv_x);
                next_s.acc_y = s.acc_y + 20'(conv_y);
            end
            next_s.dec_cnt = (s.dec_cnt == DEC_LAST) ? 4'h0
                           : s.dec_cnt + 4'h1;
            // DC removal is the high-pass half; groups alternate sign.
            if (s.dec_cnt == DEC_LAST) begin
                next_s.chop = ~s.chop;
                hx = s.acc_x + 20'(conv_x) - s.dc_x;
                hy = s.acc_y + 20'(conv_y) - s.dc_y;
                next_s.dc_x = s.dc_x + (hx >>> `AAP_DC_SHIFT);
                next_s.dc_y = s.dc_y + (hy >>> `AAP_DC_SHIFT);
                // A sample arriving mid-computation is dropped.
                if (s.cst == aap_pkg::AAP_IDLE) begin
                    next_s.cst = aap_pkg::AAP_RUN;
                    next_s.iter = 4'h0;
                    next_s.cx = hx[19] ? -22'(hx) : 22'(hx);
                    next_s.cy = hx[19] ? -22'(hy) : 22'(hy);
                    next_s.cz = (hx[19] ^ s.chop) ? 16'h8000 : 16'h0000;
                end
            end
        end

        // Vectoring rotation, one step per clock.
        case (s.cst)
            aap_pkg::AAP_IDLE: begin
                next_s.iter = 4'h0;
            end
            aap_pkg::AAP_RUN: begin
                sx = s.cx >>> s.iter;
                sy = s.cy >>> s.iter;
                if (!s.cy[21]) begin
                    next_s.cx = s.cx + sy;
                    next_s.cy = s.cy - sx;
                    next_s.cz = s.cz + atan_step(s.iter);
                end else begin
                    next_s.cx = s.cx - sy;
                    next_s.cy = s.cy + sx;
                    next_s.cz = s.cz - atan_step(s.iter);
                end
                next_s.iter = s.iter + 4'h1;
                if (s.iter == `AAP_CORDIC_LAST) begin
                    next_s.cst = aap_pkg::AAP_IDLE;
                    next_s.raw = next_s.cz;
                    next_s.raw_ok = 1'b1;
                end
            end
            default: begin
                next_s.cst = aap_pkg::AAP_IDLE;
            end
        endcase

        // Base tick paces the refresh; one raw sample per tick.
        next_s.tick_cnt = (s.tick_cnt == TICK_LAST) ? 9'h0
                        : s.tick_cnt + 9'h1;
        if (s.tick_cnt == TICK_LAST && s.raw_ok) begin
            // Deviations from the first sample survive the wrap.
            delta = s.raw - s.avg_first;
            if (s.avg_cnt == 7'h0) begin
                next_s.avg_first = s.raw;
                sum = 24'sh0;
            end else begin
                sum = s.avg_sum + 24'(signed'(delta));
            end
            next_s.avg_sum = sum;
            if (s.avg_cnt >= avg_last) begin
                next_s.avg_cnt = 7'h0;
                avg = ((s.avg_cnt == 7'h0) ? s.raw : s.avg_first)
                    + 16'(sum >>> rate);
                // Filter state tracks the input while bypassed.
                diff = avg - s.iir_y;
                iir_in = s.iir_y + 16'(signed'(diff)
                       >>> s.iir_shift[3:0]);
                if (!s.ctrl[`AAP_IIR_ON] || !s.iir_init) begin
                    iir_in = avg;
                end
                next_s.iir_y = iir_in;
                next_s.iir_init = 1'b1;
                res = process_angle(s, iir_in, temp_in, oh, uh);
                next_s.angle_out = res;
                next_s.angle_valid = 1'b1;
            end else begin
                next_s.avg_cnt = s.avg_cnt + 7'h1;
            end
        end

        // Register writes; fault bits clear on writing one.
        if (reg_write) begin
            case (reg_addr)
                `AAP_CTRL: next_s.ctrl = reg_wdata;
                `AAP_IIR_SHIFT: next_s.iir_shift = reg_wdata;
                `AAP_TEMP_COEFF: next_s.temp_coeff = reg_wdata;
                `AAP_TEMP_REF: next_s.temp_ref = reg_wdata;
                `AAP_PRE_GAIN_Z: next_s.pre_gain_zero = reg_wdata;
                `AAP_LOW_BOUND: next_s.low_bound = reg_wdata;
                `AAP_HIGH_BOUND: next_s.high_bound = reg_wdata;
                `AAP_STROKE_SC: next_s.stroke_scale = reg_wdata;
                `AAP_PRE_CORR_Z: next_s.pre_corr_zero = reg_wdata;
                `AAP_FINAL_Z: next_s.final_zero_shift = reg_wdata;
                `AAP_UPPER_LIM: next_s.upper_limit = reg_wdata;
                `AAP_LOWER_LIM: next_s.lower_limit = reg_wdata;
                `AAP_FAULT_WORD: begin
                    if (reg_wdata[`AAP_OVER_BIT]) begin
                        next_s.over_bound_flag = 1'b0;
                    end
                    if (reg_wdata[`AAP_UNDER_BIT]) begin
                        next_s.under_bound_flag = 1'b0;
                    end
                end
                default: begin
                    if (reg_addr[4]) begin
                        next_s.coeffs[reg_addr[3:0]] = reg_wdata;
                    end
                end
            endcase
        end
        // Setting after the clear lets a same-cycle event win.
        if (oh) begin
            next_s.over_bound_flag = 1'b1;
        end
        if (uh) begin
            next_s.under_bound_flag = 1'b1;
        end

        // Read data stands one cycle after the read strobe.
        next_s.rdata = 16'h0;
        if (reg_read) begin
            case (reg_addr)
                `AAP_CTRL: next_s.rdata = s.ctrl;
                `AAP_IIR_SHIFT: next_s.rdata = s.iir_shift;
                `AAP_TEMP_COEFF: next_s.rdata = s.temp_coeff;
                `AAP_TEMP_REF: next_s.rdata = s.temp_ref;
                `AAP_PRE_GAIN_Z: next_s.rdata = s.pre_gain_zero;
                `AAP_LOW_BOUND: next_s.rdata = s.low_bound;
                `AAP_HIGH_BOUND: next_s.rdata = s.high_bound;
                `AAP_STROKE_SC: next_s.rdata = s.stroke_scale;
                `AAP_PRE_CORR_Z: next_s.rdata = s.pre_corr_zero;
                `AAP_FINAL_Z: next_s.rdata = s.final_zero_shift;
                `AAP_UPPER_LIM: next_s.rdata = s.upper_limit;
                `AAP_LOWER_LIM: next_s.rdata = s.lower_limit;
                `AAP_FAULT_WORD: begin
                    next_s.rdata[`AAP_OVER_BIT] = s.over_bound_flag;
                    next_s.rdata[`AAP_UNDER_BIT] = s.under_bound_flag;
                end
                `AAP_ANGLE_OUT: next_s.rdata = {4'h0, s.angle_out};
                `AAP_RAW_ANGLE: next_s.rdata = s.raw;
                default: begin
                    if (reg_addr[4]) begin
                        next_s.rdata = s.coeffs[reg_addr[3:0]];
                    end
                end
            endcase
        end
    end

    // State register; every field takes a constant at reset.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.ctrl <= `AAP_CTRL_RST;
            s.stroke_scale <= `AAP_SCALE_RST;
            s.upper_limit <= `AAP_UPPER_RST;
            s.iir_shift <= `AAP_SHIFT_RST;
            s.cst <= aap_pkg::AAP_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register.
    assign reg_rdata = s.rdata;
    assign angle_out = s.angle_out;
    assign angle_valid = s.angle_valid;
    assign over_bound_flag = s.over_bound_flag;
    assign under_bound_flag = s.under_bound_flag;

endmodule : aap_pipeline
`default_nettype wire
